// ### design/acs_cfg.svh
// constants for the chip-select readout link: widths, edge counts, timing
// assumes a 10 MHz system clock on both ends
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// ************************************************************
// result format and edge counts
// ************************************************************
`define ACS_RES_BITS      18
`define ACS_DATA_EDGES    18
`define ACS_BUSY_EDGES    19

// ************************************************************
// timing (ns) and derived cycle counts
// ************************************************************
`define ACS_CLK_NS        100
// conversion bounds are plain defaults, not device figures
`define ACS_MINIMUM_CONVERSION_TIME_NS  500
`define ACS_MAXIMUM_CONVERSION_TIME_NS  700
`define ACS_MINIMUM_CONVERSION_TIME_CYC ((`ACS_MINIMUM_CONVERSION_TIME_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_MAXIMUM_CONVERSION_TIME_CYC (`ACS_MAXIMUM_CONVERSION_TIME_NS / `ACS_CLK_NS)
`define ACS_SCLK_NS       800
`define ACS_SCLK_DIV      (`ACS_SCLK_NS / `ACS_CLK_NS)
`define ACS_SYNC_MARGIN   4

// ************************************************************
// reset values and buffering
// ************************************************************
`define ACS_RST_TRIG      1'b0
`define ACS_RST_SEL       1'b1
`define ACS_RST_SCLK      1'b0
`define ACS_FIFO_DEPTH    8

`endif

// ### design/acs_pkg.sv
// types shared by both ends of the chip-select readout link
// assumes nothing of its surroundings
package acs_pkg;

    typedef enum logic [2:0] {
        DEV_IDLE = 3'b001,
        DEV_CONV = 3'b010,
        DEV_ACQ  = 3'b100
    } acs_dev_state_e;

    typedef enum logic [5:0] {
        HST_IDLE  = 6'b000001,
        HST_START = 6'b000010,
        HST_CONV  = 6'b000100,
        HST_SEL   = 6'b001000,
        HST_SHIFT = 6'b010000,
        HST_DONE  = 6'b100000
    } acs_host_state_e;

endpackage : acs_pkg

// ### design/acs_link_if.sv
// link pins between converter end and host end
// the data line has a pull-up: it reads high while the converter does not drive it
`timescale 1ns/1ps
interface acs_link_if;
    logic convTrig;
    logic selIn;
    logic sclk;
    logic dataOut;
    logic dataOe_n;
    logic dataLine;

    assign dataLine = dataOe_n ? 1'b1 : dataOut;

    modport device (input convTrig, input selIn, input sclk, output dataOut, output dataOe_n);
    modport host   (output convTrig, output selIn, output sclk, input dataLine);
endinterface : acs_link_if

// ### design/acs_dev.sv
// converter end: conversion start, chip-select mode tracking and serial readout
// assumes link pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps
`include "acs_cfg.svh"

// Summary of operation
// - select high at trigger rise: chip-select mode
// - trigger rise: output off; with select high, sample and convert
// - conversion runs on internal timing only
// - 3-wire no busy: host keeps trigger high
// - 3-wire: trigger fall shows MSB, bits follow
// - 3-wire: off after 18th fall or trigger rise
// - host captures on falling clock edges
// - 3-wire busy: host holds trigger low
// - busy variants: low busy bit, then data
// - 3-wire busy: off after 19th fall
// - 4-wire: trigger high until all read
// - 4-wire no busy: host holds select high
// - 4-wire: select fall shows MSB, bits follow
// - 4-wire: off after 18th fall or select rise
// - shared line: next select after previous off
// - 4-wire: trigger and select never both low
// - 4-wire busy: host holds select low
// - 4-wire busy: off after 19th fall
// - select low at trigger rise: daisy-chain mode
// - results are two's complement
module acs_dev #(
    parameter int RES_W    = `ACS_RES_BITS,
    parameter int CONV_CYC = `ACS_MAXIMUM_CONVERSION_TIME_CYC
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // link
    acs_link_if.device            link,
    // user side
    input  wire logic [RES_W-1:0] sampleIn,
    output logic                  busyConv,
    output logic                  acqPhase,
    output logic                  csModeOut,
    output logic                  daisyModeOut,
    output logic                  resultValid,
    output logic [RES_W-1:0]      resultOut
);

    // ************************************************************
    // elaboration checks and local constants
    // ************************************************************
    localparam int TW     = $clog2(CONV_CYC + 1);
    localparam int P_TRIG = 2;
    localparam int P_SEL  = 1;
    localparam int P_SCLK = 0;

    if (CONV_CYC < 1) begin : g_chk_conv
        $error("conversion cycle count must be at least one");
    end
    if (RES_W < 2) begin : g_chk_res
        $error("result width too small");
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] pinMeta_r;
    logic [2:0] pinMeta_nxt;
    logic [2:0] pinSync_r;
    logic [2:0] pinSync_nxt;
    logic [2:0] pinPrev_r;
    logic [2:0] pinPrev_nxt;

    always_comb begin
        pinMeta_nxt = {link.convTrig, link.selIn, link.sclk};
        pinSync_nxt = pinMeta_r;
        pinPrev_nxt = pinSync_r;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinMeta_r <= {`ACS_RST_TRIG, `ACS_RST_SEL, `ACS_RST_SCLK};
            pinSync_r <= {`ACS_RST_TRIG, `ACS_RST_SEL, `ACS_RST_SCLK};
            pinPrev_r <= {`ACS_RST_TRIG, `ACS_RST_SEL, `ACS_RST_SCLK};
        end else begin
            pinMeta_r <= pinMeta_nxt;
            pinSync_r <= pinSync_nxt;
            pinPrev_r <= pinPrev_nxt;
        end
    end

    // ************************************************************
    // edge detection
    // ************************************************************
    logic trigRise;
    logic sclkFall;
    logic csLvl;
    logic csPrevLvl;
    logic csFall;
    logic csRise;

    // the effective select is high only while both trigger and select are high:
    // in 3-wire use select is tied high, in 4-wire use the trigger stays high
    assign trigRise  = pinSync_r[P_TRIG] & ~pinPrev_r[P_TRIG];
    assign sclkFall  = ~pinSync_r[P_SCLK] & pinPrev_r[P_SCLK];
    assign csLvl     = pinSync_r[P_TRIG] & pinSync_r[P_SEL];
    assign csPrevLvl = pinPrev_r[P_TRIG] & pinPrev_r[P_SEL];
    assign csFall    = ~csLvl & csPrevLvl;
    assign csRise    = csLvl & ~csPrevLvl;

    // ************************************************************
    // conversion and readout state
    // ************************************************************
    acs_pkg::acs_dev_state_e state_r;
    acs_pkg::acs_dev_state_e state_nxt;
    logic [TW-1:0]           timer_r;
    logic [TW-1:0]           timer_nxt;
    logic [RES_W-1:0]        sample_r;
    logic [RES_W-1:0]        sample_nxt;
    logic [RES_W:0]          shift_r;
    logic [RES_W:0]          shift_nxt;
    logic [4:0]              left_r;
    logic [4:0]              left_nxt;
    logic                    outOff_r;
    logic                    outOff_nxt;
    logic                    csMode_r;
    logic                    csMode_nxt;
    logic                    daisy_r;
    logic                    daisy_nxt;
    logic                    done_r;
    logic                    done_nxt;
    logic [RES_W-1:0]        result_r;
    logic [RES_W-1:0]        result_nxt;

    always_comb begin
        state_nxt  = state_r;
        timer_nxt  = timer_r;
        sample_nxt = sample_r;
        shift_nxt  = shift_r;
        left_nxt   = left_r;
        outOff_nxt = outOff_r;
        csMode_nxt = csMode_r;
        daisy_nxt  = daisy_r;
        done_nxt   = 1'b0;
        result_nxt = result_r;
        if (trigRise && !state_r[1]) begin
            // a start always releases the line, whatever the readout was doing
            outOff_nxt = 1'b1;
            if (pinSync_r[P_SEL]) begin
                csMode_nxt = 1'b1;
                daisy_nxt  = 1'b0;
                state_nxt  = acs_pkg::DEV_CONV;
                timer_nxt  = TW'(CONV_CYC - 1);
                // input passes as two's complement, untouched
                sample_nxt = sampleIn;
            end else begin
                // daisy-chain operation is not served: line stays released
                csMode_nxt = 1'b0;
                daisy_nxt  = 1'b1;
                state_nxt  = acs_pkg::DEV_IDLE;
            end
        end else begin
            case (state_r)
                acs_pkg::DEV_IDLE: begin
                    outOff_nxt = 1'b1;
                end
                acs_pkg::DEV_CONV: begin
                    // pin levels are ignored until the internal count expires
                    if (timer_r == '0) begin
                        state_nxt  = acs_pkg::DEV_ACQ;
                        done_nxt   = 1'b1;
                        result_nxt = sample_r;
                        if (!csLvl) begin
                            // select low at the end asks for a busy bit
                            shift_nxt  = {1'b0, sample_r};
                            left_nxt   = 5'(`ACS_BUSY_EDGES);
                            outOff_nxt = 1'b0;
                        end
                    end else begin
                        timer_nxt = timer_r - TW'(1);
                    end
                end
                acs_pkg::DEV_ACQ: begin
                    if (csRise) begin
                        outOff_nxt = 1'b1;
                    end else if (csFall) begin
                        shift_nxt  = {sample_r, 1'b0};
                        left_nxt   = 5'(`ACS_DATA_EDGES);
                        outOff_nxt = 1'b0;
                    end else if (sclkFall && !outOff_r) begin
                        shift_nxt = {shift_r[RES_W-1:0], 1'b0};
                        left_nxt  = left_r - 5'd1;
                        if (left_r == 5'd1) begin
                            outOff_nxt = 1'b1;
                        end
                    end
                end
                default: begin
                    state_nxt  = acs_pkg::DEV_IDLE;
                    outOff_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r  <= acs_pkg::DEV_IDLE;
            timer_r  <= '0;
            sample_r <= '0;
            shift_r  <= '0;
            left_r   <= '0;
            outOff_r <= 1'b1;
            csMode_r <= 1'b0;
            daisy_r  <= 1'b0;
            done_r   <= 1'b0;
            result_r <= '0;
        end else begin
            state_r  <= state_nxt;
            timer_r  <= timer_nxt;
            sample_r <= sample_nxt;
            shift_r  <= shift_nxt;
            left_r   <= left_nxt;
            outOff_r <= outOff_nxt;
            csMode_r <= csMode_nxt;
            daisy_r  <= daisy_nxt;
            done_r   <= done_nxt;
            result_r <= result_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // a trigger rise during conversion is not a new start; the count runs out
    assign link.dataOut  = shift_r[RES_W];
    assign link.dataOe_n = outOff_r;
    assign busyConv      = state_r[1];
    assign acqPhase      = state_r[2];
    assign csModeOut     = csMode_r;
    assign daisyModeOut  = daisy_r;
    assign resultValid   = done_r;
    assign resultOut     = result_r;

endmodule : acs_dev

// ### design/acs_host.sv
// host end: drives trigger, select and serial clock, captures results into a FIFO
// assumes the converter end on the other side of acs_link_if; data line has a pull-up
`timescale 1ns/1ps
`include "acs_cfg.svh"

// ************************************************************
// word FIFO
// ************************************************************
module acs_fifo #(
    parameter int W     = `ACS_RES_BITS,
    parameter int DEPTH = `ACS_FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk_depth
        $error("depth must be a power of two, at least two");
    end

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0]  wrPtr_r;
    logic [AW:0]  wrPtr_nxt;
    logic [AW:0]  rdPtr_r;
    logic [AW:0]  rdPtr_nxt;
    logic         push;
    logic         pop;

    assign inReady  = !((wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]));
    assign outValid = (wrPtr_r != rdPtr_r);
    assign outData  = mem_r[rdPtr_r[AW-1:0]];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always_comb begin
        wrPtr_nxt = wrPtr_r + (AW+1)'(push);
        rdPtr_nxt = rdPtr_r + (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
        end
    end

    // storage needs no reset; empty flag hides stale words
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wrPtr_r[AW-1:0]] <= inData;
        end
    end
endmodule : acs_fifo

// ************************************************************
// host sequencer
// ************************************************************
module acs_host #(
    parameter int RES_W    = `ACS_RES_BITS,
    parameter int SCLK_DIV = `ACS_SCLK_DIV,
    parameter int WAIT_CYC = `ACS_MAXIMUM_CONVERSION_TIME_CYC + `ACS_SYNC_MARGIN,
    parameter int DEPTH    = `ACS_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // link
    acs_link_if.host         link,
    // user control
    input  wire logic        runEn,
    input  wire logic        fourWire,
    input  wire logic        withBusy,
    output logic             frameBusy,
    // result stream
    output logic             wordValid,
    input  wire logic        wordReady,
    output logic [RES_W-1:0] wordData
);
    localparam int HALF = SCLK_DIV / 2;
    localparam int PW   = $clog2(SCLK_DIV);
    localparam int TW   = $clog2(WAIT_CYC + SCLK_DIV + 1);
    if (SCLK_DIV < 4 || (SCLK_DIV % 2) != 0) begin : g_chk_div
        $error("serial clock divider must be even and at least four");
    end
    if (`ACS_MINIMUM_CONVERSION_TIME_CYC < 2) begin : g_chk_min
        $error("minimum conversion time too short to lower select in time");
    end

    logic                    dinMeta_r;
    logic                    dinSync_r;
    acs_pkg::acs_host_state_e state_r;
    acs_pkg::acs_host_state_e state_nxt;
    logic                    trig_r;
    logic                    trig_nxt;
    logic                    sel_r;
    logic                    sel_nxt;
    logic                    sclk_r;
    logic                    sclk_nxt;
    logic [TW-1:0]           timer_r;
    logic [TW-1:0]           timer_nxt;
    logic [PW-1:0]           phase_r;
    logic [PW-1:0]           phase_nxt;
    logic [4:0]              falls_r;
    logic [4:0]              falls_nxt;
    logic [RES_W:0]          shreg_r;
    logic [RES_W:0]          shreg_nxt;
    logic                    four_r;
    logic                    four_nxt;
    logic                    busy_r;
    logic                    busy_nxt;
    logic                    fifoReady;
    logic [4:0]              need;

    assign need = busy_r ? 5'(`ACS_BUSY_EDGES) : 5'(`ACS_DATA_EDGES);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dinMeta_r <= 1'b1;
            dinSync_r <= 1'b1;
        end else begin
            dinMeta_r <= link.dataLine;
            dinSync_r <= dinMeta_r;
        end
    end

    always_comb begin
        state_nxt = state_r;
        trig_nxt  = trig_r;
        sel_nxt   = sel_r;
        sclk_nxt  = sclk_r;
        timer_nxt = timer_r;
        phase_nxt = phase_r;
        falls_nxt = falls_r;
        shreg_nxt = shreg_r;
        four_nxt  = four_r;
        busy_nxt  = busy_r;
        case (state_r)
            acs_pkg::HST_IDLE: begin
                trig_nxt = 1'b0;
                sel_nxt  = 1'b1;
                sclk_nxt = 1'b0;
                // full FIFO holds off the next conversion
                if (runEn && fifoReady) begin
                    four_nxt  = fourWire;
                    busy_nxt  = withBusy;
                    state_nxt = acs_pkg::HST_START;
                end
            end
            acs_pkg::HST_START: begin
                trig_nxt  = 1'b1;
                timer_nxt = TW'(WAIT_CYC);
                state_nxt = acs_pkg::HST_CONV;
            end
            acs_pkg::HST_CONV: begin
                if (busy_r) begin
                    // lowered one cycle after start, well before the minimum
                    if (four_r) begin
                        sel_nxt = 1'b0;
                    end else begin
                        trig_nxt = 1'b0;
                    end
                end
                if (timer_r != '0) begin
                    timer_nxt = timer_r - TW'(1);
                end else if (!busy_r) begin
                    if (four_r) begin
                        sel_nxt = 1'b0;
                    end else begin
                        trig_nxt = 1'b0;
                    end
                    timer_nxt = TW'(SCLK_DIV);
                    state_nxt = acs_pkg::HST_SEL;
                end else if (!dinSync_r) begin
                    state_nxt = acs_pkg::HST_SHIFT;
                    phase_nxt = '0;
                    sclk_nxt  = 1'b1;
                end
            end
            acs_pkg::HST_SEL: begin
                if (timer_r != '0) begin
                    timer_nxt = timer_r - TW'(1);
                end else begin
                    state_nxt = acs_pkg::HST_SHIFT;
                    phase_nxt = '0;
                    sclk_nxt  = 1'b1;
                end
            end
            acs_pkg::HST_SHIFT: begin
                phase_nxt = (phase_r == PW'(SCLK_DIV - 1)) ? '0 : phase_r + PW'(1);
                sclk_nxt  = (phase_nxt < PW'(HALF));
                if (phase_r == PW'(HALF - 1)) begin
                    // bit is taken just as the clock falls
                    shreg_nxt = {shreg_r[RES_W-1:0], dinSync_r};
                    falls_nxt = falls_r + 5'd1;
                    if (falls_r + 5'd1 == need) begin
                        state_nxt = acs_pkg::HST_DONE;
                    end
                end
            end
            acs_pkg::HST_DONE: begin
                // select up first; trigger drops a cycle later in idle
                sel_nxt   = 1'b1;
                falls_nxt = '0;
                state_nxt = acs_pkg::HST_IDLE;
            end
            default: begin
                state_nxt = acs_pkg::HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= acs_pkg::HST_IDLE;
            trig_r  <= `ACS_RST_TRIG;
            sel_r   <= `ACS_RST_SEL;
            sclk_r  <= `ACS_RST_SCLK;
            timer_r <= '0;
            phase_r <= '0;
            falls_r <= '0;
            shreg_r <= '0;
            four_r  <= 1'b0;
            busy_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            trig_r  <= trig_nxt;
            sel_r   <= sel_nxt;
            sclk_r  <= sclk_nxt;
            timer_r <= timer_nxt;
            phase_r <= phase_nxt;
            falls_r <= falls_nxt;
            shreg_r <= shreg_nxt;
            four_r  <= four_nxt;
            busy_r  <= busy_nxt;
        end
    end

    assign link.convTrig = trig_r;
    assign link.selIn    = sel_r;
    assign link.sclk     = sclk_r;
    assign frameBusy     = !state_r[0];

    acs_fifo #(.W(RES_W), .DEPTH(DEPTH)) u_fifo (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inValid  (state_r[5]),
        .inReady  (fifoReady),
        .inData   (shreg_r[RES_W-1:0]),
        .outValid (wordValid),
        .outReady (wordReady),
        .outData  (wordData)
    );

endmodule : acs_host

// ### tb/acs_link_checker.sv
// link checker: timing relations on the converter/host pins
// assumes it is instantiated beside acs_link_if, pins sampled on clk
`timescale 1ns/1ps
module acs_link_checker (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link pins
    input wire logic convTrig,
    input wire logic selIn,
    input wire logic sclk,
    input wire logic dataOut,
    input wire logic dataOe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic       sclkPrev_r, sclkPrev_nxt;
    logic [4:0] fallPipe_r, fallPipe_nxt;
    logic [4:0] fallCnt_r, fallCnt_nxt;
    // ************************************************************
    // sclk fall history; pins pass a synchroniser, so look back a few clocks
    // ************************************************************
    always_comb begin
        sclkPrev_nxt = sclk;
        fallPipe_nxt = {fallPipe_r[3:0], sclkPrev_r & ~sclk};
        fallCnt_nxt  = dataOe_n ? 5'h00 : fallCnt_r + {4'h0, fallPipe_nxt[0]};
    end
    always_ff @(posedge clk) begin
        sclkPrev_r <= sys_rst ? 1'b0 : sclkPrev_nxt;
        fallPipe_r <= sys_rst ? 5'h00 : fallPipe_nxt;
        fallCnt_r  <= sys_rst ? 5'h00 : fallCnt_nxt;
    end
    sequence s_selRise; $rose(convTrig && selIn); endsequence
    sequence s_sclkHigh; sclk [*3] ##1 !sclk; endsequence
    // the converter sees pins through two flops and an edge compare: its answer shows three clocks late
    property p_release_conv; $rose(convTrig) |-> ##3 dataOe_n [*7]; endproperty
    a_release_conv: assert property (p_release_conv) else $error("line driven during conversion");
    property p_release_sel; s_selRise |-> ##[0:4] dataOe_n; endproperty
    a_release_sel: assert property (p_release_sel) else $error("line kept after select rise");
    property p_start_drive; $fell(dataOe_n) |-> !($past(convTrig, 3) && $past(selIn, 3)); endproperty
    a_start_drive: assert property (p_start_drive) else $error("drive while deselected");
    property p_no_both_low; !(!convTrig && !selIn); endproperty
    a_no_both_low: assert property (p_no_both_low) else $error("trigger and select both low");
    property p_bits_on_fall;
        !dataOe_n && $past(dataOe_n) == 1'b0 && $changed(dataOut) |-> |fallPipe_r;
    endproperty
    a_bits_on_fall: assert property (p_bits_on_fall) else $error("data moved without sclk fall");
    property p_edge_limit; !dataOe_n |-> fallCnt_r <= 5'd19; endproperty
    a_edge_limit: assert property (p_edge_limit) else $error("driven past last edge");
    property p_last_release; fallCnt_r == 5'd19 |-> ##[1:5] dataOe_n; endproperty
    a_last_release: assert property (p_last_release) else $error("no release after 19 falls");
    property p_sclk_half; $rose(sclk) |=> s_sclkHigh; endproperty
    a_sclk_half: assert property (p_sclk_half) else $error("sclk high phase wrong");
endmodule : acs_link_checker

// ### tb/adc_chip_select_serial_readout_tb.sv
// bench: converter end and host end joined by acs_link_if, all four modes
// assumes the design defaults: 18-bit words, 8-deep FIFO, 10 MHz clock
`timescale 1ns/1ps
module adc_chip_select_serial_readout_tb;
    logic        clk = 1'b0, sysRst = 1'b1, runEn = 1'b0, fourWire = 1'b0;
    logic        withBusy = 1'b0, wordReady = 1'b0, prevBusy = 1'b0;
    logic        busyConv, acqPhase, csModeOut, daisyModeOut, resultValid, frameBusy, wordValid;
    logic [17:0] sampleIn = 18'h00043, resultOut, wordData;
    logic [17:0] rnd = 18'h00043;
    logic [17:0] expQ[$];
    int          mismatches = 0, num_checks = 0;
    always #50 clk = ~clk;
    acs_link_if link ();
    acs_dev acs_dev_i (.clk(clk), .sys_rst(sysRst), .link(link), .sampleIn(sampleIn),
        .busyConv(busyConv), .acqPhase(acqPhase), .csModeOut(csModeOut), .daisyModeOut(daisyModeOut),
        .resultValid(resultValid), .resultOut(resultOut));
    acs_host acs_host_i (.clk(clk), .sys_rst(sysRst), .link(link), .runEn(runEn),
        .fourWire(fourWire), .withBusy(withBusy), .frameBusy(frameBusy),
        .wordValid(wordValid), .wordReady(wordReady), .wordData(wordData));
    acs_link_checker acs_link_checker_i (.clk(clk), .sys_rst(sysRst), .convTrig(link.convTrig),
        .selIn(link.selIn), .sclk(link.sclk), .dataOut(link.dataOut), .dataOe_n(link.dataOe_n));
    function automatic logic [17:0] lfsr(input logic [17:0] v);
        return {v[16:0], v[17] ^ v[10]};
    endfunction : lfsr
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    // ************************************************************
    // sample tracking: input changes only mid-conversion, after capture
    // ************************************************************
    always @(negedge clk) begin
        if (busyConv === 1'b1 && prevBusy === 1'b0) expQ.push_back(sampleIn);
        if (busyConv === 1'b1) begin
            rnd = lfsr(rnd);
            sampleIn <= rnd;
        end
        if (resultValid === 1'b1) begin
            check(resultOut, expQ[$]);
            check({15'h0, acqPhase, daisyModeOut, csModeOut}, 18'h00005);
        end
        prevBusy <= busyConv;
    end
    // ************************************************************
    // per mode: fill FIFO with reader stalled, then drain
    // ************************************************************
    initial begin
        repeat (10) @(negedge clk);
        sysRst = 1'b0;
        for (int m = 0; m < 4; m++) begin
            // second reset in mid-run, with the host idle between modes
            if (m == 2) begin
                sysRst = 1'b1;
                repeat (2) @(negedge clk);
                check({12'h0, busyConv, acqPhase, csModeOut, daisyModeOut, frameBusy, wordValid}, 18'h00000);
                sysRst = 1'b0;
            end
            fourWire = m[1];
            withBusy = m[0];
            // corner values first: most negative or most positive code
            sampleIn = {m[0], {17{~m[0]}}};
            runEn = 1'b1;
            for (int t = 0; t < 3000 && expQ.size() < 8; t++) @(negedge clk);
            for (int t = 0; t < 400 && frameBusy !== 1'b0; t++) @(negedge clk);
            repeat (400) @(negedge clk);
            check({17'h0, frameBusy}, 18'h00000);
            check(18'(expQ.size()), 18'd8);
            runEn = 1'b0;
            wordReady = 1'b1;
            for (int w = 0; w < 8; w++) begin
                for (int t = 0; t < 20 && wordValid !== 1'b1; t++) @(negedge clk);
                check(wordData, expQ.pop_front());
                @(negedge clk);
            end
            check({17'h0, wordValid}, 18'h00000);
            wordReady = 1'b0;
        end
        conclude();
    end
    initial begin
        #3000000;
        mismatches++;
        conclude();
    end
endmodule : adc_chip_select_serial_readout_tb
